//--- include/dshbp_cfg.svh
// Constants for the dual style host bus port
`ifndef DSHBP_CFG_SVH
`define DSHBP_CFG_SVH
`define DSHBP_ADDR_W 7
`define DSHBP_SPACE_BIT 6
`define DSHBP_NUM_CLASS 3
`define DSHBP_CLK_MHZ 20
`define DSHBP_EOS_OFFSET 7'h7f
`define DSHBP_EOS_HOLD_NS 100
`define DSHBP_EOS_HOLD_CYC ((`DSHBP_EOS_HOLD_NS * `DSHBP_CLK_MHZ + 999) / 1000)
`define DSHBP_EMPTY_VECTOR 8'h00
`define DSHBP_DATA_RST 8'h00
`endif

//--- include/dshbp_pkg.sv
// Types for the dual style host bus port
`default_nettype none
package dshbp_pkg;
    typedef struct packed {
        logic cs_n;
        logic rd_ds_n;
        logic wr_rw_n;
        logic ack_chain_in_n;
        logic [6:0] addr;
    } dshbp_pins_s;
    typedef struct packed {
        logic valid;
        logic write;
        logic global_space;
        logic [2:0] channel;
        logic [6:0] offset;
        logic [7:0] wdata;
    } dshbp_reg_req_s;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_ACCESS, ST_HOLD, ST_WAIT
    } dshbp_state_e;
endpackage : dshbp_pkg
`default_nettype wire

//--- src/dshbp_port.sv
// Host bus port: strobe decode, cycle sequencing, acknowledge chain and request gating
`include "dshbp_cfg.svh"
`default_nettype none
module dshbp_port #(
    parameter int NUM_CLASS = `DSHBP_NUM_CLASS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic bus_style_select,
    input wire dshbp_pkg::dshbp_pins_s pins,
    input wire logic [7:0] data_in,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] channel_access_reg,
    input wire logic chain_enable,
    input wire logic [NUM_CLASS-1:0] svc_req_raw,
    input wire logic [NUM_CLASS-1:0][6:0] svc_match,
    input wire logic [NUM_CLASS-1:0][7:0] svc_vector,
    output logic [7:0] data_out_q,
    output logic data_oe_q,
    output logic transfer_ack_n_q,
    output logic ack_chain_out_n_q,
    output logic [NUM_CLASS-1:0] service_req_n_q,
    output logic [NUM_CLASS-1:0] service_request_status_q,
    output logic [NUM_CLASS-1:0] svc_ack_q,
    output dshbp_pkg::dshbp_reg_req_s reg_req_q
);
    import dshbp_pkg::*;

    localparam logic [3:0] HOLD_CYC = 4'(`DSHBP_EOS_HOLD_CYC);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    dshbp_pins_s pins_s1_q, pins_s2_q;
    logic [7:0] data_s1_q, data_s2_q;
    logic style_s1_q, style_s2_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            pins_s1_q <= '1;
            pins_s2_q <= '1;
            style_s1_q <= 1'b1;
            style_s2_q <= 1'b1;
            data_s1_q <= `DSHBP_DATA_RST;
            data_s2_q <= `DSHBP_DATA_RST;
        end else begin
            pins_s1_q <= pins;
            pins_s2_q <= pins_s1_q;
            style_s1_q <= bus_style_select;
            style_s2_q <= style_s1_q;
            data_s1_q <= data_in;
            data_s2_q <= data_s1_q;
        end
    end
    // ****************************************
    // Strobe decode
    // ****************************************
    function automatic logic bus_selected(input dshbp_pins_s p, input logic style);
        logic strobe;
        strobe = style ? (!p.rd_ds_n || !p.wr_rw_n) : !p.rd_ds_n;
        return strobe && (!p.cs_n || !p.ack_chain_in_n);
    endfunction : bus_selected
    function automatic logic bus_write(input dshbp_pins_s p, input logic style);
        return style ? !p.wr_rw_n : !p.wr_rw_n;
    endfunction : bus_write
    function automatic logic read_strobe(input dshbp_pins_s p, input logic style);
        return style ? !p.rd_ds_n : (!p.rd_ds_n && p.wr_rw_n);
    endfunction : read_strobe
    logic sel_now;
    assign sel_now = bus_selected(pins_s2_q, style_s2_q);
    // ****************************************
    // Acknowledge match and pending lookup
    // ****************************************
    logic [NUM_CLASS-1:0] hit;
    logic matched, pending;
    logic [1:0] hit_idx;
    always_comb begin
        matched = 1'b0;
        pending = 1'b0;
        hit_idx = 2'd0;
        for (int i = NUM_CLASS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                matched = 1'b1;
                hit_idx = 2'(i);
                pending = service_request_status_q[i];
            end
        end
    end
    // ****************************************
    // Cycle sequencer
    // ****************************************
    dshbp_state_e state_q;
    logic cyc_write_q, cyc_ack_q;
    logic [6:0] cyc_addr_q;
    logic [NUM_CLASS-1:0] hit_q;

    genvar g;
    for (g = 0; g < NUM_CLASS; g++) begin : g_hit
        assign hit[g] = hit_q[g];
        always_ff @(posedge clk) begin
            if (reset) begin
                hit_q[g] <= 1'b0;
            end else if (state_q == ST_SETUP) begin
                hit_q[g] <= cyc_ack_q && (cyc_addr_q == svc_match[g]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cyc_write_q <= 1'b0;
            cyc_ack_q <= 1'b0;
            cyc_addr_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (sel_now) begin
                        state_q <= ST_SETUP;
                        cyc_ack_q <= !pins_s2_q.ack_chain_in_n;
                        cyc_write_q <= pins_s2_q.ack_chain_in_n
                                       && bus_write(pins_s2_q, style_s2_q);
                        cyc_addr_q <= pins_s2_q.addr;
                    end
                end
                ST_SETUP: state_q <= ST_ACCESS;
                ST_ACCESS: begin
                    if (cyc_ack_q && !matched) begin
                        state_q <= ST_WAIT;
                    end else if (cyc_ack_q && !pending && chain_enable) begin
                        state_q <= ST_WAIT;
                    end else begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD, ST_WAIT: begin
                    if (!sel_now) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // ****************************************
    // Register request and data path
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_req_q <= '0;
        end else begin
            reg_req_q.valid <= (state_q == ST_SETUP) && !cyc_ack_q;
            if (state_q == ST_SETUP) begin
                reg_req_q.write <= cyc_write_q;
                reg_req_q.global_space <= cyc_addr_q[`DSHBP_SPACE_BIT];
                reg_req_q.channel <= cyc_addr_q[`DSHBP_SPACE_BIT] ? 3'h0 : channel_access_reg;
                reg_req_q.offset <= cyc_addr_q;
                reg_req_q.wdata <= data_s2_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            data_out_q <= `DSHBP_DATA_RST;
        end else if (state_q == ST_ACCESS) begin
            if (!cyc_ack_q) begin
                data_out_q <= reg_rdata;
            end else if (pending) begin
                data_out_q <= svc_vector[hit_idx];
            end else begin
                data_out_q <= `DSHBP_EMPTY_VECTOR;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            data_oe_q <= 1'b0;
        end else begin
            data_oe_q <= (state_q == ST_HOLD) && !cyc_write_q && sel_now
                         && read_strobe(pins_s2_q, style_s2_q);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            transfer_ack_n_q <= 1'b1;
            ack_chain_out_n_q <= 1'b1;
        end else begin
            transfer_ack_n_q <= !((state_q == ST_ACCESS || state_q == ST_HOLD) && sel_now
                                  && !(state_q == ST_ACCESS && cyc_ack_q && !matched)
                                  && !(state_q == ST_ACCESS && cyc_ack_q && !pending
                                       && chain_enable)) || state_q == ST_WAIT;
            ack_chain_out_n_q <= !(state_q == ST_ACCESS ? (cyc_ack_q && matched && !pending
                                   && chain_enable) : (state_q == ST_WAIT && sel_now
                                   && !ack_chain_out_n_q));
        end
    end
    // ****************************************
    // Service request gating
    // ****************************************
    logic [NUM_CLASS-1:0] masked_q;
    logic [3:0] hold_cnt_q;
    logic eos_write;
    assign eos_write = reg_req_q.valid && reg_req_q.write && reg_req_q.global_space
                       && reg_req_q.offset == `DSHBP_EOS_OFFSET;

    always_ff @(posedge clk) begin
        if (reset) begin
            svc_ack_q <= '0;
            masked_q <= '0;
            hold_cnt_q <= '0;
        end else begin
            svc_ack_q <= '0;
            if (hold_cnt_q != 4'h0) begin
                hold_cnt_q <= hold_cnt_q - 4'h1;
                if (hold_cnt_q == 4'h1) begin
                    masked_q <= '0;
                end
            end
            if (eos_write) begin
                hold_cnt_q <= HOLD_CYC;
            end
            if (state_q == ST_HOLD && !sel_now && cyc_ack_q
                && service_request_status_q[hit_idx]) begin
                svc_ack_q[hit_idx] <= 1'b1;
                masked_q[hit_idx] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            service_request_status_q <= '0;
            service_req_n_q <= '1;
        end else begin
            service_request_status_q <= svc_req_raw & ~masked_q;
            service_req_n_q <= ~(svc_req_raw & ~masked_q);
        end
    end
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_sel_starts_cycle: assert property (state_q == ST_IDLE && sel_now |=> state_q == ST_SETUP)
        else $error("selection did not start a cycle");
    a_setup_then_access: assert property (state_q == ST_SETUP |=> state_q == ST_ACCESS)
        else $error("setup not followed by access");
    a_ack_bounded_time: assert property ($rose(sel_now) && state_q == ST_IDLE
        && pins_s2_q.ack_chain_in_n
        |-> ##[3:4] !transfer_ack_n_q || !sel_now)
        else $error("transfer acknowledge late");
    a_ack_released: assert property (state_q != ST_IDLE && !sel_now |=> ##1 transfer_ack_n_q)
        else $error("transfer acknowledge held after strobe removal");
    a_drive_only_read: assert property (data_oe_q |-> $past(sel_now) && !cyc_write_q)
        else $error("data driven outside read strobe");
    a_nomatch_silent: assert property (state_q == ST_ACCESS && cyc_ack_q && !matched
        |=> transfer_ack_n_q && ack_chain_out_n_q)
        else $error("unmatched acknowledge answered");
    a_chain_passes: assert property (state_q == ST_ACCESS && cyc_ack_q && matched && !pending
        && chain_enable |=> !ack_chain_out_n_q && transfer_ack_n_q)
        else $error("chain-out missing");
    a_empty_vector: assert property (state_q == ST_ACCESS && cyc_ack_q && matched && !pending
        && !chain_enable |=> data_out_q == 8'h00)
        else $error("non-zero empty vector");
    a_req_negated: assert property (svc_ack_q[hit_idx] |=> !service_request_status_q[hit_idx])
        else $error("request not negated after acknowledge");
    a_eos_holdoff: assert property (eos_write |=> ##1 $stable(masked_q))
        else $error("request reasserted too soon");
    c_read_cycle: cover property (state_q == ST_HOLD && !cyc_write_q && !cyc_ack_q);
    c_write_cycle: cover property (reg_req_q.valid && reg_req_q.write);
    c_vector_cycle: cover property (|svc_ack_q);
    c_chain_pass: cover property (!ack_chain_out_n_q);
endmodule : dshbp_port
`default_nettype wire

//--- tb/dshbp_host_model.sv
// Host processor bus model driving select, strobe, address and write data pins
`default_nettype none
module dshbp_host_model (
    input wire logic clk,
    input wire logic style,
    input wire logic transfer_ack_n,
    input wire logic ack_chain_out_n,
    input wire logic data_oe,
    input wire logic [7:0] data_out,
    output var dshbp_pkg::dshbp_pins_s pins,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import dshbp_pkg::*;

    initial begin
        pins = '{1'b1, 1'b1, 1'b1, 1'b1, 7'h2a};
        data_in = 8'h5a;
    end

    // ************************************************************
    // One bus cycle, bounded wait for either answer
    // ************************************************************
    task automatic cycle(input logic is_ack, input logic wr, input logic [6:0] a,
                         input logic [7:0] d, output logic [7:0] rd, output int lat,
                         output logic got_ack, output logic got_chain, output logic oe_seen);
        int k;
        k = 0;
        lat = 0;
        oe_seen = 1'b0;
        @(posedge clk);
        pins.addr <= a;
        data_in <= wr ? d : ~data_in;
        @(posedge clk);
        // Chip select and chain-in never together; rd_ds_n low on every cycle in style 0, on reads only in style 1
        pins <= '{is_ack, style ? wr : 1'b0, !wr, !is_ack, a};
        while (lat < 20 && transfer_ack_n && ack_chain_out_n) begin
            @(posedge clk);
            lat++;
        end
        got_ack = !transfer_ack_n;
        got_chain = !ack_chain_out_n;
        rd = data_out;
        // Strobe held past the answer so the port keeps driving the bus
        repeat (2) begin
            @(posedge clk);
            oe_seen = oe_seen | data_oe;
        end
        pins <= '{1'b1, 1'b1, 1'b1, 1'b1, ~a};
        data_in <= ~data_in;
        while (k < 10 && !(transfer_ack_n && ack_chain_out_n)) begin
            @(posedge clk);
            k++;
        end
        repeat (3) @(posedge clk);
    endtask : cycle
endmodule : dshbp_host_model
`default_nettype wire

//--- tb/dshbp_port_tb.sv
// Self-checking bench for the host bus port
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("[ERR] %s expected %h seen %h", what, exp, got); \
        end \
    end
module dshbp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dshbp_pkg::*;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic bus_style_select = 1'b1;
    dshbp_pins_s pins;
    logic [7:0] data_in;
    logic [7:0] reg_rdata;
    logic [2:0] channel_access_reg = 3'h5;
    logic chain_enable = 1'b0;
    logic [2:0] svc_req_raw = 3'h0;
    logic [2:0][6:0] svc_match = {7'h15, 7'h0d, 7'h09};
    logic [2:0][7:0] svc_vector = {8'h33, 8'h22, 8'h11};
    logic [2:0] req_sync1_q = 3'h7;
    logic [2:0] req_sync2_q = 3'h7;
    logic [7:0] data_out_q;
    logic data_oe_q;
    logic transfer_ack_n_q;
    logic ack_chain_out_n_q;
    logic [2:0] service_req_n_q;
    logic [2:0] service_request_status_q;
    logic [2:0] svc_ack_q;
    dshbp_reg_req_s reg_req_q;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] rd;
    int lat;
    logic got_ack;
    logic got_chain;
    logic oe_seen;

    // Core register file answers with the inverted offset
    assign reg_rdata = ~{1'b0, reg_req_q.offset};

    always #25 clk = ~clk;

    // Host interrupt logic sees the requests only through two flops
    always @(posedge clk) begin
        req_sync1_q <= service_req_n_q;
        req_sync2_q <= req_sync1_q;
    end

    dshbp_port i_dut (.clk(clk), .reset(reset), .bus_style_select(bus_style_select),
        .pins(pins), .data_in(data_in), .reg_rdata(reg_rdata),
        .channel_access_reg(channel_access_reg), .chain_enable(chain_enable),
        .svc_req_raw(svc_req_raw), .svc_match(svc_match), .svc_vector(svc_vector),
        .data_out_q(data_out_q), .data_oe_q(data_oe_q), .transfer_ack_n_q(transfer_ack_n_q),
        .ack_chain_out_n_q(ack_chain_out_n_q), .service_req_n_q(service_req_n_q),
        .service_request_status_q(service_request_status_q), .svc_ack_q(svc_ack_q),
        .reg_req_q(reg_req_q));

    dshbp_host_model i_host (.clk(clk), .style(bus_style_select),
        .transfer_ack_n(transfer_ack_n_q), .ack_chain_out_n(ack_chain_out_n_q),
        .data_oe(data_oe_q), .data_out(data_out_q), .pins(pins), .data_in(data_in));

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            $display("[ERR] run cycles expected below 4000 seen %0d", cycles);
            close_out();
        end
    end

    task automatic bus(input logic is_ack, input logic wr, input logic [6:0] a,
                       input logic [7:0] d);
        i_host.cycle(is_ack, wr, a, d, rd, lat, got_ack, got_chain, oe_seen);
    endtask : bus

    task automatic t_reset_values();
        `CHK("transfer ack idle", 1'b1, transfer_ack_n_q)
        `CHK("chain out idle", 1'b1, ack_chain_out_n_q)
        `CHK("bus enable idle", 1'b0, data_oe_q)
        `CHK("requests idle", 3'h7, service_req_n_q)
        `CHK("core request idle", dshbp_reg_req_s'(0), reg_req_q)
    endtask : t_reset_values

    task automatic t_styles();
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            bus_style_select <= s[0];
            bus(1'b0, 1'b1, 7'h21, 8'ha5 ^ s[7:0]);
            `CHK("write flag", 1'b1, reg_req_q.write)
            `CHK("write data", 8'ha5 ^ s[7:0], reg_req_q.wdata)
            `CHK("channel", 3'h5, reg_req_q.channel)
            `CHK("channel space", 1'b0, reg_req_q.global_space)
            bus(1'b0, 1'b1, 7'h45, 8'h3c);
            `CHK("global space", 1'b1, reg_req_q.global_space)
            bus(1'b0, 1'b0, 7'h12 + s[6:0], 8'h00);
            `CHK("read flag", 1'b0, reg_req_q.write)
            `CHK("read data", ~{1'b0, 7'h12 + s[6:0]}, rd)
            `CHK("ack latency", 1'b1, (lat >= 5 && lat <= 6))
            `CHK("bus driven in read", 1'b1, oe_seen)
            `CHK("bus released", 1'b0, data_oe_q)
            `CHK("ack released", 1'b1, transfer_ack_n_q)
        end
    endtask : t_styles

    task automatic t_service();
        int k;
        @(posedge clk);
        svc_req_raw <= 3'h2;
        repeat (3) @(posedge clk);
        `CHK("request out", 3'h5, service_req_n_q)
        bus(1'b1, 1'b0, 7'h0d, 8'h00);
        `CHK("ack on match", 1'b1, got_ack)
        `CHK("class vector", 8'h22, rd)
        `CHK("request negated", 3'h7, service_req_n_q)
        `CHK("synced request", 3'h7, req_sync2_q)
        fork
            bus(1'b0, 1'b1, 7'h7f, 8'h00);
            begin
                k = 0;
                while (k < 20 && !(reg_req_q.valid && reg_req_q.write)) begin
                    @(posedge clk);
                    k++;
                end
                @(posedge clk);
                `CHK("status held", 3'h0, service_request_status_q)
                repeat (4) @(posedge clk);
                `CHK("status back", 3'h2, service_request_status_q)
            end
        join
        @(posedge clk);
        svc_req_raw <= 3'h0;
        repeat (3) @(posedge clk);
    endtask : t_service

    task automatic t_invalid();
        @(posedge clk);
        chain_enable <= 1'b1;
        bus(1'b1, 1'b0, 7'h09, 8'h00);
        `CHK("chain out on match", 1'b1, got_chain)
        `CHK("no ack when passed", 1'b0, got_ack)
        @(posedge clk);
        chain_enable <= 1'b0;
        bus(1'b1, 1'b0, 7'h15, 8'h00);
        `CHK("empty vector ack", 1'b1, got_ack)
        `CHK("empty vector", 8'h00, rd)
        bus(1'b1, 1'b0, 7'h7e, 8'h00);
        `CHK("silent ack", 1'b0, got_ack)
        `CHK("silent chain", 1'b0, got_chain)
    endtask : t_invalid

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset_values();
        t_styles();
        t_service();
        t_invalid();
        close_out();
    end
endmodule : dshbp_port_tb
`default_nettype wire
